/* File: output_arbiter_threshold_regs.sv */
// output arbiter, input fan-out, diagnosis, trims and threshold registers
`timescale 1ns/100ps
`default_nettype none
`include "arb_consts.svh"
module output_arbiter_threshold_regs #(
  parameter int N_FBK = 12,
  parameter int N_CUR = 4,
  parameter int TRIM_W = 6,
  parameter logic [2:0] SRC_INIT_LO = 3'h1,
  parameter logic [2:0] SRC_INIT_HI = 3'h2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] launch_trigger_pins,
  input wire logic [N_FBK-1:0] ds_fbk,
  input wire logic [N_CUR-1:0] cur_fbk,
  input wire logic boost_cmp,
  input wire logic amp_sign,
  input wire logic boost_amp_sign,
  input wire arb_pkg::cmd_bank_t core_cmd,
  input wire arb_pkg::cmd_bank_t out_access,
  input wire logic [3:0] oc_req,
  input wire logic spi_wr,
  input wire logic spi_rd,
  input wire logic [8:0] spi_addr,
  input wire logic [15:0] spi_wdata,
  input wire logic [3:0] core_reg_wr,
  input wire arb_pkg::addr_bank_t core_reg_addr,
  input wire arb_pkg::data_bank_t core_reg_wdata,
  input wire logic [3:0] core_trip_wr,
  input wire arb_pkg::trip_bank_t core_trip_data,
  input wire logic [4:0] bs_init,
  input wire logic [4:0] bs_high,
  output logic [3:0][4+N_FBK+N_CUR:0] core_in_q,
  output logic [arb_pkg::N_OUT-1:0] merged_cmd_q,
  output logic [arb_pkg::N_OUT-1:0] diag_fault_q,
  output logic [15:0] spi_rdata_q,
  output logic [14:0] hs_drain_source_level_q,
  output logic [14:0] hs_source_level_q,
  output logic [17:0] ls_drain_source_level_q,
  output logic [7:0] trip_level_q,
  output logic boost_ok_q,
  output logic [TRIM_W-1:0] meas_trim_q,
  output logic [TRIM_W-1:0] boost_trim_q,
  output logic oc_busy_q,
  output logic oc_done_q
);
  import arb_pkg::*;

  localparam int IN_W = 4 + N_FBK + N_CUR + 1;
  localparam logic [15:0] SETTLE = 16'(`TRIM_SETTLE_CYC);

  // two-flop synchronisers for everything arriving from pins or analog
  logic [IN_W+1:0] sync1_q;
  logic [IN_W+1:0] sync2_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {boost_amp_sign, amp_sign, boost_cmp, cur_fbk, ds_fbk,
                  launch_trigger_pins};
      sync2_q <= sync1_q;
    end
  end

  logic [3:0] pins_s;
  logic [N_FBK-1:0] ds_s;
  logic [N_CUR-1:0] cur_s;
  logic boost_s;
  logic amp_s;
  logic bamp_s;
  assign {bamp_s, amp_s, boost_s, cur_s, ds_s, pins_s} = sync2_q;

  // one copy per core, all loaded on the same edge
  genvar gc;
  generate
    for (gc = 0; gc < N_CORE; gc++) begin : g_fan
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          core_in_q[gc] <= '0;
        end else begin
          core_in_q[gc] <= {boost_ok_q, cur_s, ds_s, pins_s};
        end
      end
    end
  endgenerate

  // a core drives an output only while it owns it
  logic [N_OUT-1:0] merged_d;
  always_comb begin
    merged_d = '0;
    for (int c = 0; c < N_CORE; c++) begin
      merged_d = merged_d | (core_cmd[c] & out_access[c]);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      merged_cmd_q <= '0;
      diag_fault_q <= '0;
    end else begin
      merged_cmd_q <= merged_d;
      // fault: output switched on yet its comparator still trips
      diag_fault_q <= merged_cmd_q & ds_s[N_OUT-1:0];
    end
  end

  // level registers: 0 hs drain-source, 1 hs source, 2/3 low side
  logic [3:0][15:0] lvl_q;
  logic [3:0][15:0] lvl_d;

  function automatic logic [8:0] lvl_addr(input int r);
    case (r)
      0: lvl_addr = `HS_DS_ADDR;
      1: lvl_addr = `HS_SRC_ADDR;
      2: lvl_addr = `LS_DS_A_ADDR;
      default: lvl_addr = `LS_DS_B_ADDR;
    endcase
  endfunction

  function automatic int lvl_base(input int r);
    case (r)
      0: lvl_base = 0;
      1: lvl_base = 0;
      2: lvl_base = 5;
      default: lvl_base = 10;
    endcase
  endfunction

  always_comb begin
    lvl_d = lvl_q;
    for (int r = 0; r < 4; r++) begin
      if (spi_wr && spi_addr == lvl_addr(r)) begin
        // host write is never locked and beats core writes
        lvl_d[r] = (r == 3) ? {13'h0000, spi_wdata[2:0]}
                            : {1'b0, spi_wdata[14:0]};
      end else begin
        // low core index applied last so it wins a collision
        for (int c = N_CORE - 1; c >= 0; c--) begin
          if (core_reg_wr[c] && core_reg_addr[c] == lvl_addr(r)) begin
            for (int f = 0; f < 5; f++) begin
              if ((r != 3 || f == 0) &&
                  out_access[c][lvl_base(r) + f]) begin
                lvl_d[r][`LVL_W*f +: `LVL_W] =
                  core_reg_wdata[c][`LVL_W*f +: `LVL_W];
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lvl_q <= {4{`LVL_RST}};
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // bootstrap init overrides the stored high-side source levels
  logic [14:0] src_eff;
  always_comb begin
    src_eff = lvl_q[1][14:0];
    for (int f = 0; f < 5; f++) begin
      if (bs_init[f]) begin
        src_eff[3*f +: 3] = bs_high[f] ? SRC_INIT_HI : SRC_INIT_LO;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hs_drain_source_level_q <= '0;
      hs_source_level_q <= '0;
      ls_drain_source_level_q <= '0;
    end else begin
      hs_drain_source_level_q <= lvl_q[0][14:0];
      hs_source_level_q <= src_eff;
      ls_drain_source_level_q <= {lvl_q[3][2:0], lvl_q[2][14:0]};
    end
  end

  // trip setting, grants and debounce setup
  logic [15:0] trip_q;
  logic [15:0] grant_q;
  logic [15:0] filt_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trip_q <= `TRIP_RST;
    end else if (spi_wr && spi_addr == `TRIP_ADDR) begin
      trip_q <= {8'h00, spi_wdata[`TRIP_W-1:0]};
    end else begin
      // the backdoor port never reaches this register, only the
      // dedicated trip port does
      for (int c = N_CORE - 1; c >= 0; c--) begin
        if (core_trip_wr[c] && grant_q[c]) begin
          trip_q <= {8'h00, core_trip_data[c]};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      grant_q <= `GRANT_RST;
    end else if (spi_wr && spi_addr == `GRANT_ADDR) begin
      grant_q <= {12'h000, spi_wdata[`GRANT_W-1:0]};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      filt_q <= `FILT_RST;
    end else if (spi_wr && spi_addr == `FILT_ADDR) begin
      filt_q <= {3'h0, spi_wdata[12:0]};
    end else begin
      for (int c = N_CORE - 1; c >= 0; c--) begin
        if (core_reg_wr[c] && core_reg_addr[c] == `FILT_ADDR &&
            grant_q[c]) begin
          filt_q <= {3'h0, core_reg_wdata[c][12:0]};
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trip_level_q <= '0;
    end else begin
      trip_level_q <= trip_q[`TRIP_W-1:0];
    end
  end

  // debounce: counts samples of the new level; a sample back at the
  // held level clears or backs off the count
  logic [`FILT_CNT_W-1:0] fcnt_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fcnt_q <= '0;
      boost_ok_q <= 1'b0;
    end else if (boost_s != boost_ok_q) begin
      if (fcnt_q >= filt_q[`FILT_CNT_W-1:0]) begin
        boost_ok_q <= boost_s;
        fcnt_q <= '0;
      end else begin
        fcnt_q <= fcnt_q + 1'b1;
      end
    end else if (!filt_q[`FILT_TYPE_BIT]) begin
      fcnt_q <= '0;
    end else if (fcnt_q != '0) begin
      fcnt_q <= fcnt_q - 1'b1;
    end
  end

  // register readback, one cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      spi_rdata_q <= '0;
    end else if (spi_rd) begin
      if (spi_addr == `HS_DS_ADDR) begin
        spi_rdata_q <= lvl_q[0];
      end else if (spi_addr == `HS_SRC_ADDR) begin
        spi_rdata_q <= {1'b0, src_eff};
      end else if (spi_addr == `LS_DS_A_ADDR) begin
        spi_rdata_q <= lvl_q[2];
      end else if (spi_addr == `LS_DS_B_ADDR) begin
        spi_rdata_q <= lvl_q[3];
      end else if (spi_addr == `TRIP_ADDR) begin
        spi_rdata_q <= trip_q;
      end else if (spi_addr == `GRANT_ADDR) begin
        spi_rdata_q <= grant_q;
      end else if (spi_addr == `FILT_ADDR) begin
        spi_rdata_q <= filt_q;
      end else begin
        spi_rdata_q <= '0;
      end
    end
  end

  // core requests held until the sequencer can take them
  logic meas_pend_q;
  logic boot_pend_q;
  logic oc_start;
  oc_state_t oc_q;
  assign oc_start = (oc_q == OC_IDLE) && (boot_pend_q || meas_pend_q);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meas_pend_q <= 1'b0;
    end else if (|oc_req) begin
      meas_pend_q <= 1'b1; // set beats the clear at start
    end else if (oc_start && !boot_pend_q) begin
      meas_pend_q <= 1'b0;
    end
  end

  // successive approximation of the trim dac, msb first; the boost
  // trim runs once after reset before any core request is served
  logic tgt_q;
  logic [TRIM_W-1:0] bit_q;
  logic [15:0] wait_q;
  logic sign_now;
  assign sign_now = tgt_q ? bamp_s : amp_s;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oc_q <= OC_IDLE;
      boot_pend_q <= 1'b1;
      tgt_q <= 1'b0;
      bit_q <= '0;
      wait_q <= '0;
      meas_trim_q <= '0;
      boost_trim_q <= '0;
      oc_busy_q <= 1'b0;
      oc_done_q <= 1'b0;
    end else begin
      oc_done_q <= 1'b0;
      case (oc_q)
        OC_IDLE: begin
          if (oc_start) begin
            tgt_q <= boot_pend_q;
            boot_pend_q <= 1'b0;
            bit_q <= {1'b1, {(TRIM_W-1){1'b0}}};
            if (boot_pend_q) begin
              boost_trim_q <= '0;
            end else begin
              meas_trim_q <= '0;
            end
            oc_busy_q <= 1'b1;
            oc_q <= OC_SET;
          end
        end
        OC_SET: begin
          if (tgt_q) begin
            boost_trim_q <= boost_trim_q | bit_q;
          end else begin
            meas_trim_q <= meas_trim_q | bit_q;
          end
          wait_q <= SETTLE;
          oc_q <= OC_WAIT;
        end
        OC_WAIT: begin
          // let the amplifier settle before judging the sign
          wait_q <= wait_q - 16'h0001;
          if (wait_q == 16'h0001) begin
            oc_q <= OC_DECIDE;
          end
        end
        OC_DECIDE: begin
          if (sign_now) begin
            if (tgt_q) begin
              boost_trim_q <= boost_trim_q & ~bit_q;
            end else begin
              meas_trim_q <= meas_trim_q & ~bit_q;
            end
          end
          bit_q <= bit_q >> 1;
          if (bit_q[0]) begin
            oc_busy_q <= 1'b0;
            oc_done_q <= 1'b1;
            oc_q <= OC_IDLE;
          end else begin
            oc_q <= OC_SET;
          end
        end
        default: oc_q <= OC_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: arb_consts.svh */
// constants for the output arbiter and threshold register block
`ifndef ARB_CONSTS_SVH
`define ARB_CONSTS_SVH
`define HS_DS_ADDR 9'h18a
`define HS_SRC_ADDR 9'h18b
`define LS_DS_A_ADDR 9'h18c
`define LS_DS_B_ADDR 9'h18d
`define TRIP_ADDR 9'h19b
`define GRANT_ADDR 9'h19c
`define FILT_ADDR 9'h19d
`define LVL_RST 16'h0000
`define TRIP_RST 16'h0000
`define GRANT_RST 16'h0000
`define FILT_RST 16'h0001
`define LVL_W 3
`define TRIP_W 8
`define GRANT_W 4
`define FILT_TYPE_BIT 12
`define FILT_CNT_W 12
`define CLK_NS 100
`define TRIM_SETTLE_NS 1000
`define TRIM_SETTLE_CYC ((`TRIM_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* File: arb_pkg.sv */
// types shared by the output arbiter block
package arb_pkg;
  localparam int N_CORE = 4;
  localparam int N_OUT = 12;
  typedef logic [N_CORE-1:0][N_OUT-1:0] cmd_bank_t;
  typedef logic [N_CORE-1:0][8:0] addr_bank_t;
  typedef logic [N_CORE-1:0][15:0] data_bank_t;
  typedef logic [N_CORE-1:0][7:0] trip_bank_t;
  typedef enum logic [1:0] {
    OC_IDLE = 2'b00,
    OC_SET = 2'b01,
    OC_WAIT = 2'b10,
    OC_DECIDE = 2'b11
  } oc_state_t;
endpackage

/* File: trim_sense_model.sv */
// analog offset sense model for the measurement and boost amplifiers
`timescale 1ns/100ps
`default_nettype none
module trim_sense_model #(
  parameter int TRIM_W = 6,
  parameter logic [TRIM_W-1:0] MEAS_OFS = 'h2b,
  parameter logic [TRIM_W-1:0] BOOST_OFS = 'h15
) (
  input wire logic [TRIM_W-1:0] meas_trim_q,
  input wire logic [TRIM_W-1:0] boost_trim_q,
  output logic amp_sign,
  output logic boost_amp_sign
);
  // sign is high while the trim overshoots, so a search settles on the offset
  assign amp_sign = meas_trim_q > MEAS_OFS;
  assign boost_amp_sign = boost_trim_q > BOOST_OFS;
endmodule
`default_nettype wire

/* File: output_arbiter_threshold_regs_asserts.sv */
// port checker for the output arbiter and threshold registers
`timescale 1ns/100ps
`default_nettype none
`include "arb_consts.svh"
module arb_port_checker
  import arb_pkg::*;
#(
  parameter int N_FBK = 12,
  parameter int N_CUR = 4,
  parameter int TRIM_W = 6
) (
  input wire logic clock,
  input wire logic nrst,
  input wire arb_pkg::cmd_bank_t core_cmd,
  input wire arb_pkg::cmd_bank_t out_access,
  input wire logic spi_wr,
  input wire logic spi_rd,
  input wire logic [8:0] spi_addr,
  input wire logic [15:0] spi_wdata,
  input wire logic [3:0][4+N_FBK+N_CUR:0] core_in_q,
  input wire logic [arb_pkg::N_OUT-1:0] merged_cmd_q,
  input wire logic [15:0] spi_rdata_q,
  input wire logic [7:0] trip_level_q,
  input wire logic [TRIM_W-1:0] meas_trim_q,
  input wire logic oc_busy_q,
  input wire logic oc_done_q
);
  logic [N_OUT-1:0] own_cmd;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // commands that some owning core really asked for
  always_comb begin
    own_cmd = '0;
    for (int c = 0; c < N_CORE; c++)
      own_cmd = own_cmd | (core_cmd[c] & out_access[c]);
  end
  AST_FANOUT: assert property (
    core_in_q[1] == core_in_q[0] && core_in_q[2] == core_in_q[0]
    && core_in_q[3] == core_in_q[0]) else $error("core inputs differ");
  // equality, so a dropped owned command trips it as well
  AST_MERGE: assert property (
    merged_cmd_q == $past(own_cmd)) else $error("merge mismatch");
  AST_TRIP_HOST: assert property (
    spi_wr && spi_addr == `TRIP_ADDR |-> ##2
    trip_level_q == $past(spi_wdata[7:0], 2)) else $error("trip not set");
  AST_RDATA_HOLD: assert property (
    !spi_rd |=> $stable(spi_rdata_q)) else $error("read data moved");
  AST_LSB_RSVD: assert property (
    spi_rd && spi_addr == `LS_DS_B_ADDR |=> spi_rdata_q[15:3] == '0)
    else $error("reserved bits read high");
  AST_OC_DONE: assert property (
    $rose(oc_busy_q) |-> ##[1:200] oc_done_q) else $error("trim hung");
  AST_DONE_PULSE: assert property (
    oc_done_q |=> !oc_done_q) else $error("done held");
  AST_TRIM_HOLD: assert property (
    !oc_busy_q && !$past(oc_busy_q) |-> $stable(meas_trim_q))
    else $error("trim moved while idle");
endmodule
bind output_arbiter_threshold_regs arb_port_checker #(
  .N_FBK(N_FBK), .N_CUR(N_CUR), .TRIM_W(TRIM_W)
) u_arb_port_checker (
  .clock(clock), .nrst(nrst), .core_cmd(core_cmd),
  .out_access(out_access), .spi_wr(spi_wr), .spi_rd(spi_rd),
  .spi_addr(spi_addr), .spi_wdata(spi_wdata), .core_in_q(core_in_q),
  .merged_cmd_q(merged_cmd_q), .spi_rdata_q(spi_rdata_q),
  .trip_level_q(trip_level_q), .meas_trim_q(meas_trim_q),
  .oc_busy_q(oc_busy_q), .oc_done_q(oc_done_q)
);
`default_nettype wire

/* File: output_arbiter_threshold_regs_tb_top.sv */
// self-checking bench for the output arbiter and threshold registers
`timescale 1ns/100ps
`default_nettype none
`include "arb_consts.svh"
module output_arbiter_threshold_regs_tb_top;
  import arb_pkg::*;
  logic clock, nrst, boost_cmp, spi_wr, spi_rd, amp_sign, boost_amp_sign;
  logic boost_ok_q, oc_busy_q, oc_done_q;
  logic [3:0] pins, cur_fbk, oc_req, core_reg_wr, core_trip_wr;
  logic [4:0] bs_init, bs_high;
  logic [5:0] meas_trim_q, boost_trim_q;
  logic [7:0] trip_level_q;
  logic [8:0] spi_addr;
  logic [11:0] ds_fbk, merged_cmd_q, diag_fault_q;
  logic [14:0] hs_ds_q, hs_src_q;
  logic [17:0] ls_ds_q;
  logic [15:0] spi_wdata, spi_rdata_q;
  logic [3:0][20:0] core_in_q;
  cmd_bank_t core_cmd, out_access;
  addr_bank_t core_reg_addr;
  data_bank_t core_reg_wdata;
  trip_bank_t core_trip_data;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  logic [8:0] ad [7] = '{9'h18a, 9'h18b, 9'h18c, 9'h18d, 9'h19b, 9'h19c,
    9'h19d};
  logic [15:0] mk [7] = '{16'h7fff, 16'h7fff, 16'h7fff, 16'h0007, 16'h00ff,
    16'h000f, 16'h1fff};

  output_arbiter_threshold_regs u_output_arbiter_threshold_regs (
    .clock(clock), .nrst(nrst), .launch_trigger_pins(pins),
    .ds_fbk(ds_fbk), .cur_fbk(cur_fbk), .boost_cmp(boost_cmp),
    .amp_sign(amp_sign), .boost_amp_sign(boost_amp_sign),
    .core_cmd(core_cmd), .out_access(out_access), .oc_req(oc_req),
    .spi_wr(spi_wr), .spi_rd(spi_rd), .spi_addr(spi_addr),
    .spi_wdata(spi_wdata), .core_reg_wr(core_reg_wr),
    .core_reg_addr(core_reg_addr), .core_reg_wdata(core_reg_wdata),
    .core_trip_wr(core_trip_wr), .core_trip_data(core_trip_data),
    .bs_init(bs_init), .bs_high(bs_high), .core_in_q(core_in_q),
    .merged_cmd_q(merged_cmd_q), .diag_fault_q(diag_fault_q),
    .spi_rdata_q(spi_rdata_q), .hs_drain_source_level_q(hs_ds_q),
    .hs_source_level_q(hs_src_q), .ls_drain_source_level_q(ls_ds_q),
    .trip_level_q(trip_level_q), .boost_ok_q(boost_ok_q),
    .meas_trim_q(meas_trim_q), .boost_trim_q(boost_trim_q),
    .oc_busy_q(oc_busy_q), .oc_done_q(oc_done_q));
  trim_sense_model u_trim_sense_model (
    .meas_trim_q(meas_trim_q), .boost_trim_q(boost_trim_q),
    .amp_sign(amp_sign), .boost_amp_sign(boost_amp_sign));

  task automatic chk(string nm, logic [23:0] s, logic [23:0] e);
    tests_run++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(int k);
    repeat (k) @(negedge clock);
  endtask
  // host strobes last one cycle and are released at the next falling edge
  task automatic wr(logic [8:0] a, logic [15:0] d);
    @(negedge clock);
    {spi_wr, spi_addr, spi_wdata} = {1'b1, a, d};
    @(negedge clock);
    spi_wr = 0;
  endtask
  task automatic rc(logic [8:0] a, logic [15:0] e);
    @(negedge clock);
    {spi_rd, spi_addr} = {1'b1, a};
    @(negedge clock);
    spi_rd = 0;
    @(negedge clock);
    chk("register read", spi_rdata_q, e);
  endtask
  task automatic cw(int c, logic [8:0] a, logic [15:0] d);
    @(negedge clock);
    {core_reg_wr[c], core_reg_addr[c], core_reg_wdata[c]} = {1'b1, a, d};
    @(negedge clock);
    core_reg_wr[c] = 0;
  endtask
  task automatic ct(int c, logic [7:0] d);
    @(negedge clock);
    {core_trip_wr[c], core_trip_data[c]} = {1'b1, d};
    @(negedge clock);
    core_trip_wr[c] = 0;
    tick(2);
  endtask
  // bounded wait for the trim engine to go idle
  task automatic idle(int k);
    @(negedge clock);
    while (oc_busy_q !== 1'b0) begin
      if (k-- == 0) begin
        num_errors++;
        end_of_test();
      end
      @(negedge clock);
    end
  endtask
  // filter of length four, fed three low, one high, two low samples
  task automatic glitch(logic t, logic e);
    wr(`FILT_ADDR, {3'h0, t, 12'h003});
    boost_cmp = 1;
    tick(12);
    for (int i = 0; i < 6; i++) begin
      boost_cmp = i == 3;
      tick(1);
    end
    boost_cmp = 1;
    tick(4);
    chk("filtered boost", boost_ok_q, e);
  endtask

  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial begin
    {nrst, boost_cmp, spi_wr, spi_rd, pins, cur_fbk, oc_req} = '0;
    {core_reg_wr, core_trip_wr, ds_fbk, bs_init, bs_high} = '0;
    {core_cmd, out_access, spi_addr, spi_wdata} = '0;
    {core_reg_addr, core_reg_wdata, core_trip_data} = '0;
    tick(16);
    nrst = 1;
    idle(200);
    chk("boost trim", boost_trim_q, 6'h15);
    for (int i = 0; i < 7; i++) rc(ad[i], {15'h0, i == 6});
    for (int i = 0; i < 7; i++) wr(ad[i], 16'hffff);
    wr(9'h19a, 16'hffff);
    for (int i = 0; i < 7; i++) rc(ad[i], mk[i]);
    rc(9'h19a, 16'h0000);
    chk("trip level", trip_level_q, 8'hff);
    wr(`GRANT_ADDR, 16'h0002);
    ct(0, 8'h11);
    chk("trip level", trip_level_q, 8'hff);
    ct(1, 8'h5a);
    chk("trip level", trip_level_q, 8'h5a);
    cw(1, `TRIP_ADDR, 16'h0033);
    rc(`TRIP_ADDR, 16'h005a);
    cw(0, `FILT_ADDR, 16'h0003);
    rc(`FILT_ADDR, 16'h1fff);
    cw(1, `FILT_ADDR, 16'h0003);
    rc(`FILT_ADDR, 16'h0003);
    boost_cmp = 1;
    for (n = 0; n < 20 && boost_ok_q !== 1'b1; n++) tick(1);
    chk("filter delay", n inside {[4:8]}, 1);
    glitch(0, 1);
    glitch(1, 0);
    out_access[2] = 12'h021;
    cw(2, `HS_DS_ADDR, 16'h0000);
    cw(0, `HS_DS_ADDR, 16'h0000);
    rc(`HS_DS_ADDR, 16'h7ff8);
    chk("hs level", hs_ds_q, 15'h7ff8);
    cw(2, `LS_DS_A_ADDR, 16'h0000);
    rc(`LS_DS_A_ADDR, 16'h7ff8);
    chk("ls level", ls_ds_q, 18'h3fff8);
    bs_init = 5'h01;
    rc(`HS_SRC_ADDR, 16'h7ff9);
    chk("hs source level", hs_src_q, 15'h7ff9);
    bs_high = 5'h01;
    rc(`HS_SRC_ADDR, 16'h7ffa);
    bs_init = 5'h00;
    rc(`HS_SRC_ADDR, 16'h7fff);
    foreach (out_access[c]) out_access[c] = 12'h111 << c;
    core_cmd[0] = 12'hfff;
    core_cmd[3] = 12'hfff;
    {ds_fbk, pins, cur_fbk} = {12'h0ff, 4'ha, 4'h5};
    tick(4);
    chk("merged", merged_cmd_q, 12'h999);
    chk("diagnosis", diag_fault_q, 12'h099);
    // boost_ok_q has long since settled high again after the glitch run
    foreach (core_in_q[c]) chk("fan-out", core_in_q[c], 21'h150ffa);
    oc_req[1] = 1;
    tick(1);
    oc_req = 4'h0;
    idle(200);
    chk("meas trim", meas_trim_q, 6'h2b);
    end_of_test();
  end
endmodule
`default_nettype wire
